// File: hw/dcp_pkg.sv
// constants, types and pin bundles for the ddr2 command pin block
// assumes one 200 MHz clock that stands for the ck/ck# crossing
package dcp_pkg;
    localparam int DQ_W = 16;
    localparam int ADDR_W = 14;
    localparam int BA_W = 3;
    localparam int NBANK = 8;
    localparam int DM_W = 2;
    localparam int MR_N = 4;
    localparam int AP_BIT = 10;
    localparam int MR_BL_LSB = 0;
    localparam logic [2:0] MR_BL8 = 3'h3;
    localparam logic [3:0] BL4 = 4'h4;
    localparam logic [3:0] BL8 = 4'h8;
    localparam logic [3:0] RD_LAT = 4'h3;
    localparam int EMR_IDX = 1;
    localparam int EMR_RTT_LO = 2;
    localparam int EMR_RTT_HI = 6;
    localparam int EMR_DQSN_DIS = 10;
    localparam logic [ADDR_W-1:0] MR_RST = 14'h0000;
    localparam int RD_FIFO_D = 4;

    typedef enum logic [2:0] {
        CMD_DESEL, CMD_NOP, CMD_LMR, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD
    } dcp_cmd_e;

    typedef enum logic [1:0] {
        PS_ACTIVE, PS_PRE_PD, PS_ACT_PD, PS_SELF_REF
    } dcp_pwr_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic odt;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [DM_W-1:0] dm;
        logic [DQ_W-1:0] dq;
        logic dqs;
    } dcp_pins_s;

    typedef struct packed {
        logic valid;
        dcp_cmd_e kind;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic all_banks;
    } dcp_cmd_s;

    typedef struct packed {
        logic valid;
        logic [DM_W-1:0] be;
        logic [DQ_W-1:0] data;
    } dcp_beat_s;

    localparam dcp_pins_s PINS_RST = '{cs_n: 1'b1, ras_n: 1'b1,
        cas_n: 1'b1, we_n: 1'b1, default: '0};
endpackage : dcp_pkg

// File: hw/dcp_ddr2_pins.sv
// ddr2 device pin logic: command decode, power states, data pins
// assumes the controller pins arrive unsynchronised on clock_i
// and the array side takes commands and write beats every cycle

// ------------------------------------------------------------
// read data buffer
// ------------------------------------------------------------
module dcp_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wp_ff, rp_ff;
    logic [AW:0] cnt_ff;
    // handshakes and flags
    wire logic push = in_valid_i && in_ready_o;
    wire logic pop = out_valid_o && out_ready_i;
    wire logic [AW:0] nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o = mem_ff[rp_ff];
    // storage, pointers and a registered not-full flag
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                mem_ff[wp_ff] <= in_data_i;
            end
            wp_ff <= push ? wp_ff + 1'b1 : wp_ff;
            rp_ff <= pop ? rp_ff + 1'b1 : rp_ff;
            cnt_ff <= nxt_cnt;
            in_ready_o <= nxt_cnt != (AW+1)'(D); // ready straight from a flop
        end
    end
endmodule : dcp_fifo

// ------------------------------------------------------------
// device pin logic
// ------------------------------------------------------------
module dcp_ddr2_pins import dcp_pkg::*; (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // pins from the controller
    input wire dcp_pins_s pins_i,
    // data and strobe pins driven back
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic dqs_o,
    output logic dqs_oe_o,
    output logic dqs_n_o,
    output logic dqs_n_oe_o,
    // read data from the array
    input wire logic rd_valid_i,
    output logic rd_ready_o,
    input wire logic [DQ_W-1:0] rd_data_i,
    // decoded traffic to the array
    output dcp_cmd_s cmd_o,
    output dcp_beat_s wr_o,
    output logic [NBANK-1:0] bank_open_o,
    // power and termination state
    output dcp_pwr_e pwr_o,
    output logic clk_active_o,
    output logic cmd_buf_en_o,
    output logic odt_buf_en_o,
    output logic term_o,
    output logic term_dqsn_o
);
    dcp_pins_s s1_ff, s2_ff;
    logic cke_prev_ff, dqs_prev_ff;
    dcp_pwr_e nxt_pwr;
    logic [NBANK-1:0] nxt_open;
    logic [ADDR_W-1:0] mr_ff [MR_N];
    logic [3:0] rd_cnt_ff, rd_bl_ff, wr_left_ff;
    logic fifo_valid;
    logic [DQ_W-1:0] fifo_data;
    // command code from cs and the three strobes
    function automatic dcp_cmd_e cmd_decode(input logic cs_n,
            input logic ras_n, input logic cas_n, input logic we_n);
        if (cs_n) begin
            return CMD_DESEL;
        end
        unique case ({ras_n, cas_n, we_n})
            3'h0: return CMD_LMR;
            3'h1: return CMD_REF;
            3'h2: return CMD_PRE;
            3'h3: return CMD_ACT;
            3'h4: return CMD_WR;
            3'h5: return CMD_RD;
            3'h6, 3'h7: return CMD_NOP;
        endcase
    endfunction : cmd_decode
    // two-stage capture of every pin at the crossing
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_ff <= PINS_RST;
            s2_ff <= PINS_RST;
        end else begin
            s1_ff <= pins_i;
            s2_ff <= s1_ff;
        end
    end
    // decode of the registered pins
    wire dcp_cmd_e cur_cmd = cmd_decode(s2_ff.cs_n, s2_ff.ras_n,
        s2_ff.cas_n, s2_ff.we_n);
    wire logic cke_hold = s2_ff.cke && cke_prev_ff;
    wire logic take = (pwr_o == PS_ACTIVE) && cke_hold;
    wire logic is_act = take && cur_cmd == CMD_ACT;
    wire logic is_pre = take && cur_cmd == CMD_PRE;
    wire logic is_rd = take && cur_cmd == CMD_RD;
    wire logic is_wr = take && cur_cmd == CMD_WR;
    wire logic is_lmr = take && cur_cmd == CMD_LMR;
    wire logic [BA_W-1:0] ba = s2_ff.ba;
    wire logic [1:0] mr_sel = s2_ff.ba[1:0];
    wire logic ap = s2_ff.addr[AP_BIT];
    wire logic all_idle = bank_open_o == '0;
    wire logic cke_fall = !s2_ff.cke && cke_prev_ff;
    // mode register fields that steer the pins
    wire logic [ADDR_W-1:0] emr = mr_ff[EMR_IDX];
    wire logic rtt_en = emr[EMR_RTT_LO] || emr[EMR_RTT_HI];
    wire logic diff_en = !emr[EMR_DQSN_DIS];
    wire logic bl8 = mr_ff[0][MR_BL_LSB +: 3] == MR_BL8;
    wire logic [3:0] burst = bl8 ? BL8 : BL4;
    // power state walk under cke
    always_comb begin
        nxt_pwr = pwr_o;
        unique case (pwr_o)
            PS_ACTIVE: begin
                if (cke_fall) begin
                    nxt_pwr = (cur_cmd == CMD_REF) ? PS_SELF_REF :
                        all_idle ? PS_PRE_PD : PS_ACT_PD;
                end
            end
            // self refresh exit needs no clocked cke history
            PS_PRE_PD, PS_ACT_PD, PS_SELF_REF: begin
                if (s2_ff.cke) begin
                    nxt_pwr = PS_ACTIVE;
                end
            end
        endcase
    end
    // open bank bookkeeping
    always_comb begin
        nxt_open = bank_open_o;
        if (is_act) begin
            nxt_open[ba] = 1'b1;
        end
        if (is_pre) begin
            if (ap) begin
                nxt_open = '0;
            end else begin
                nxt_open[ba] = 1'b0;
            end
        end
        if ((is_rd || is_wr) && ap) begin
            nxt_open[ba] = 1'b0;
        end
    end
    // state, banks and buffer enables
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pwr_o <= PS_ACTIVE;
            bank_open_o <= '0;
            cke_prev_ff <= 1'b0;
            clk_active_o <= 1'b0;
            cmd_buf_en_o <= 1'b1;
            odt_buf_en_o <= 1'b1;
        end else begin
            pwr_o <= nxt_pwr;
            bank_open_o <= nxt_open;
            cke_prev_ff <= s2_ff.cke;
            clk_active_o <= s2_ff.cke;
            cmd_buf_en_o <= nxt_pwr == PS_ACTIVE;
            odt_buf_en_o <= nxt_pwr != PS_SELF_REF;
        end
    end
    // mode registers loaded from the address lines
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mr_ff <= '{default: MR_RST};
        end else if (is_lmr) begin
            mr_ff[mr_sel] <= s2_ff.addr;
        end
    end
    // command hand-off to the array
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cmd_o <= '0;
        end else begin
            cmd_o.valid <= take && cur_cmd != CMD_NOP &&
                cur_cmd != CMD_DESEL;
            cmd_o.kind <= cur_cmd;
            cmd_o.bank <= ba;
            cmd_o.addr <= s2_ff.addr;
            cmd_o.all_banks <= is_pre && ap;
        end
    end
    // termination control
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            term_o <= 1'b0;
            term_dqsn_o <= 1'b0;
        end else begin
            term_o <= s2_ff.odt && rtt_en &&
                pwr_o != PS_SELF_REF;
            term_dqsn_o <= s2_ff.odt && rtt_en && diff_en &&
                pwr_o != PS_SELF_REF;
        end
    end
    // write beats on either strobe edge, mask drops lanes
    wire logic dqs_edge = s2_ff.dqs ^ dqs_prev_ff;
    wire logic wr_beat = wr_left_ff != '0 && dqs_edge;
    wire logic all_masked = s2_ff.dm == '1;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_left_ff <= '0;
            dqs_prev_ff <= 1'b0;
            wr_o <= '0;
        end else begin
            dqs_prev_ff <= s2_ff.dqs;
            if (is_wr) begin
                wr_left_ff <= burst;
            end else if (wr_beat) begin
                wr_left_ff <= wr_left_ff - 4'h1;
            end
            wr_o.valid <= wr_beat && !all_masked;
            wr_o.be <= ~s2_ff.dm;
            wr_o.data <= s2_ff.dq;
        end
    end
    // read burst window after the read latency
    wire logic rd_win = rd_cnt_ff != '0 && rd_cnt_ff <= rd_bl_ff;
    wire logic drive = rd_win && pwr_o == PS_ACTIVE;
    wire logic nxt_dqs = drive ? !dqs_o : 1'b0;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rd_cnt_ff <= '0;
            rd_bl_ff <= BL4;
        end else if (is_rd) begin
            rd_cnt_ff <= RD_LAT + burst;
            rd_bl_ff <= burst;
        end else if (rd_cnt_ff != '0) begin
            rd_cnt_ff <= rd_cnt_ff - 4'h1;
        end
    end
    // data and strobe drivers, strobe toggles with each beat
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dq_o <= '0;
            dq_oe_o <= 1'b0;
            dqs_o <= 1'b0;
            dqs_oe_o <= 1'b0;
            dqs_n_o <= 1'b1;
            dqs_n_oe_o <= 1'b0;
        end else begin
            dq_o <= (drive && fifo_valid) ? fifo_data : dq_o;
            dq_oe_o <= drive;
            dqs_o <= nxt_dqs;
            dqs_oe_o <= drive;
            dqs_n_o <= !nxt_dqs;
            dqs_n_oe_o <= drive && diff_en;
        end
    end
    // read data queue from the array side
    dcp_fifo #(.W(DQ_W), .D(RD_FIFO_D)) u_rd_fifo (
        .clock_i(clock_i), .rst_i(rst_i),
        .in_valid_i(rd_valid_i), .in_ready_o(rd_ready_o),
        .in_data_i(rd_data_i), .out_valid_o(fifo_valid),
        .out_ready_i(drive), .out_data_o(fifo_data)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_cs_masks: assert property (
        take && s2_ff.cs_n |=> !cmd_o.valid)
        else $error("command taken with cs high");
    a_pre_all: assert property (
        is_pre && ap |=> bank_open_o == '0 && cmd_o.all_banks)
        else $error("precharge all left a bank open");
    a_act_opens: assert property (
        is_act |=> bank_open_o[$past(ba)])
        else $error("activate did not open its bank");
    a_lmr_store: assert property (
        is_lmr |=> mr_ff[$past(mr_sel)] == $past(s2_ff.addr))
        else $error("mode register not loaded");
    a_pd_blocks: assert property (
        pwr_o != PS_ACTIVE |-> !cmd_buf_en_o ##1 !cmd_o.valid)
        else $error("command taken in power-down");
    a_pd_kind: assert property (
        pwr_o == PS_ACTIVE && cke_fall && cur_cmd != CMD_REF
        |=> pwr_o == ($past(all_idle) ? PS_PRE_PD : PS_ACT_PD))
        else $error("wrong power-down kind");
    a_sr_exit: assert property (
        pwr_o == PS_SELF_REF && s2_ff.cke |=> pwr_o == PS_ACTIVE)
        else $error("self refresh exit missed");
    a_mask_drop: assert property (
        wr_beat && all_masked |=> !wr_o.valid)
        else $error("fully masked beat kept");
    a_mask_lane: assert property (
        wr_beat |=> wr_o.be == ~$past(s2_ff.dm))
        else $error("byte enable not tied to its mask");
    a_odt_off: assert property (
        !rtt_en |=> !term_o)
        else $error("termination on while disabled");
    a_rd_edge: assert property (
        dq_oe_o && $past(dq_oe_o) |-> dqs_o != $past(dqs_o))
        else $error("strobe did not toggle with read beat");
    a_dqsn_pair: assert property (
        dqs_n_oe_o |-> dqs_n_o == !dqs_o && dqs_oe_o)
        else $error("complementary strobe out of step");

    c_read_burst: cover property (dq_oe_o [*4]);
    c_write_beat: cover property (wr_beat ##1 wr_o.valid);
    c_self_ref: cover property (pwr_o == PS_SELF_REF ##1 pwr_o == PS_ACTIVE);
    c_act_pd: cover property (pwr_o == PS_ACT_PD);
endmodule : dcp_ddr2_pins

// File: verif/dcp_ctrl_model.sv
// controller model: drives the ddr2 command, mask and write data pins
// assumes one bench process calls its tasks, all timed on clock_i
module dcp_ctrl_model import dcp_pkg::*; (
    // clock
    input wire logic clock_i,
    // pins towards the device
    output dcp_pins_s pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // command and level drivers
    // -------------------------------------------------------------
    // deselected at start, clock enable already high
    initial begin
        pins_o = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
            cke: 1'b1, default: '0};
    end

    // one command for one cycle, then nop with chip select low
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a, input logic k);
        @(posedge clock_i);
        {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= c;
        pins_o.ba <= b;
        pins_o.addr <= a;
        pins_o.cke <= k;
        @(posedge clock_i);
        {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= 4'h7;
        pins_o.ba <= ~b; // stale values never linger on released lines
        pins_o.addr <= ~a;
    endtask : cmd

    // clock enable and termination request levels
    task automatic lines(input logic k, input logic o);
        @(posedge clock_i);
        pins_o.cke <= k;
        pins_o.odt <= o;
    endtask : lines

    // four beats, one on each strobe edge, mask riding with data
    task automatic burst(input logic [63:0] d, input logic [7:0] m);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            pins_o.dqs <= ~pins_o.dqs;
            pins_o.dq <= d[16*i +: 16];
            pins_o.dm <= m[2*i +: 2];
        end
        @(posedge clock_i);
        pins_o.dq <= ~pins_o.dq;
        pins_o.dm <= 2'h3;
    endtask : burst
endmodule : dcp_ctrl_model

// File: verif/dcp_ddr2_pins_test.sv
// self-checking bench for the ddr2 device pin block
// assumes the controller model drives pins_i and the bench the array side
module dcp_ddr2_pins_test;
    import dcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // clock, reset, design and partner
    // -------------------------------------------------------------
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd_valid_i = 1'b0;
    logic [DQ_W-1:0] rd_data_i = '0;
    dcp_pins_s pins;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe_o, dqs_o, dqs_oe_o, dqs_n_o, dqs_n_oe_o, rd_ready_o;
    dcp_cmd_s cmd_o;
    dcp_beat_s wr_o;
    logic [NBANK-1:0] bank_open_o;
    dcp_pwr_e pwr_o;
    logic clk_active_o, cmd_buf_en_o, odt_buf_en_o, term_o, term_dqsn_o;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    logic [17:0] beats[$];

    always #2.5 clock_i = ~clock_i;

    dcp_ctrl_model m (.clock_i(clock_i), .pins_o(pins));

    dcp_ddr2_pins u_dut (.clock_i(clock_i), .rst_i(rst_i), .pins_i(pins),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
        .dqs_n_o(dqs_n_o), .dqs_n_oe_o(dqs_n_oe_o), .rd_valid_i(rd_valid_i),
        .rd_ready_o(rd_ready_o), .rd_data_i(rd_data_i), .cmd_o(cmd_o),
        .wr_o(wr_o), .bank_open_o(bank_open_o), .pwr_o(pwr_o),
        .clk_active_o(clk_active_o), .cmd_buf_en_o(cmd_buf_en_o),
        .odt_buf_en_o(odt_buf_en_o), .term_o(term_o),
        .term_dqsn_o(term_dqsn_o));

    // collects kept write beats; a hang ends the run
    always @(posedge clock_i) begin
        if (wr_o.valid === 1'b1)
            beats.push_back({wr_o.be, wr_o.data});
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end

    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // waits a bounded time for a decoded command pulse
    task automatic wait_cmd(output dcp_cmd_s c);
        c = '0;
        for (int i = 0; i < 8 && c.valid !== 1'b1; i++) begin
            @(posedge clock_i);
            #1 if (cmd_o.valid === 1'b1) c = cmd_o;
        end
    endtask : wait_cmd

    // issues a command and compares the decoded result
    task automatic issue(input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a, input dcp_cmd_e k, input logic all);
        dcp_cmd_s got;
        dcp_cmd_s e;
        e = '{1'b1, k, b, a, all};
        m.cmd(c, b, a, 1'b1);
        wait_cmd(got);
        check(32'(got), 32'(e));
    endtask : issue

    task automatic settle();
        repeat (4) @(posedge clock_i);
        #1;
    endtask : settle

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_decode();
        dcp_cmd_s got;
        check(32'(dqs_n_o), 32'h1);
        check(32'(pwr_o), 32'(PS_ACTIVE));
        issue(4'h3, 3'h2, 14'h1abc, CMD_ACT, 1'b0);
        check(32'(bank_open_o), 32'h04);
        m.cmd(4'hb, 3'h1, 14'h0123, 1'b1);
        wait_cmd(got);
        check(32'(got.valid), 32'h0);
        issue(4'h2, 3'h2, 14'h0000, CMD_PRE, 1'b0);
        issue(4'h3, 3'h1, 14'h0011, CMD_ACT, 1'b0);
        issue(4'h3, 3'h5, 14'h0022, CMD_ACT, 1'b0);
        check(32'(bank_open_o), 32'h22);
        issue(4'h2, 3'h3, 14'h0400, CMD_PRE, 1'b1);
        check(32'(bank_open_o), 32'h00);
    endtask : t_decode

    task automatic t_write();
        beats.delete();
        issue(4'h4, 3'h0, 14'h0010, CMD_WR, 1'b0);
        m.burst(64'h4444_3333_2222_1111, 8'he4);
        settle();
        check(32'(beats.size()), 32'h3);
        check(32'(beats[0]), 32'h31111);
        check(32'(beats[1]), 32'h22222);
        check(32'(beats[2]), 32'h13333);
    endtask : t_write

    task automatic t_read();
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            rd_valid_i <= (i < 4);
            rd_data_i <= 16'ha000 + 16'(i);
        end
        #1 check(32'(rd_ready_o), 32'h0);
        issue(4'h5, 3'h0, 14'h0020, CMD_RD, 1'b0);
        for (int i = 0; i < 8 && dq_oe_o !== 1'b1; i++) begin
            @(posedge clock_i);
            #1;
        end
        for (int i = 0; i < 4; i++) begin
            check(32'({dq_oe_o, dqs_oe_o, dqs_n_oe_o}), 32'h7);
            check(32'(dq_o), 32'(16'ha000 + 16'(i)));
            check(32'({dqs_o, dqs_n_o}), 32'(i[0] ? 2'h1 : 2'h2));
            @(posedge clock_i);
            #1;
        end
        check(32'({dq_oe_o, rd_ready_o}), 32'h1);
    endtask : t_read

    task automatic t_term();
        issue(4'h0, 3'h1, 14'h0004, CMD_LMR, 1'b0);
        m.lines(1'b1, 1'b1);
        settle();
        check(32'({term_o, term_dqsn_o}), 32'h3);
        issue(4'h0, 3'h1, 14'h0404, CMD_LMR, 1'b0);
        settle();
        check(32'({term_o, term_dqsn_o}), 32'h2);
        issue(4'h0, 3'h1, 14'h0000, CMD_LMR, 1'b0);
        settle();
        check(32'(term_o), 32'h0);
        m.lines(1'b1, 1'b0);
    endtask : t_term

    task automatic t_power();
        dcp_cmd_s got;
        m.lines(1'b0, 1'b0);
        settle();
        check(32'({pwr_o, clk_active_o, cmd_buf_en_o}), 32'({PS_PRE_PD, 2'h0}));
        m.cmd(4'h3, 3'h6, 14'h0001, 1'b0);
        wait_cmd(got);
        check(32'(got.valid), 32'h0);
        m.lines(1'b1, 1'b0);
        settle();
        check(32'(pwr_o), 32'(PS_ACTIVE));
        issue(4'h3, 3'h4, 14'h0002, CMD_ACT, 1'b0);
        m.lines(1'b0, 1'b0);
        settle();
        check(32'(pwr_o), 32'(PS_ACT_PD));
        m.lines(1'b1, 1'b0);
        settle();
        issue(4'h2, 3'h0, 14'h0400, CMD_PRE, 1'b1);
        m.cmd(4'h1, 3'h0, 14'h0000, 1'b0);
        settle();
        check(32'({pwr_o, odt_buf_en_o}), 32'({PS_SELF_REF, 1'b0}));
        m.lines(1'b1, 1'b0);
        settle();
        check(32'({pwr_o, cmd_buf_en_o}), 32'({PS_ACTIVE, 1'b1}));
    endtask : t_power

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        settle();
        t_decode();
        t_write();
        t_read();
        t_term();
        t_power();
        results();
    end
endmodule : dcp_ddr2_pins_test
